// file: bus_cmd_pkg.sv
/*
 * Shared constants for the status-word bus command controller.
 * Assumes a 50 MHz system clock; all users reference names as bus_cmd_pkg::name.
 */
package bus_cmd_pkg;
	// Clock period in picoseconds
	localparam int CLK_PERIOD_PS    = 20000;
	// Least wait from bus grant to command enable, ns
	localparam int GRANT_ENABLE_NS  = 105;
	// Least wait from bus grant to command issue in system-bus mode, ns
	localparam int GRANT_ISSUE_NS   = 115;
	// Cycle counts, least times rounded up
	localparam int GRANT_ENABLE_CYC = (GRANT_ENABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GRANT_ISSUE_CYC  = (GRANT_ISSUE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Width of the status word
	localparam int STATUS_W         = 3;
	// Status word encodings (active-low lines as seen on the pins)
	localparam logic [2:0] ST_IRQ_ACK  = 3'h0;
	localparam logic [2:0] ST_IO_READ  = 3'h1;
	localparam logic [2:0] ST_IO_WRITE = 3'h2;
	localparam logic [2:0] ST_HALT     = 3'h3;
	localparam logic [2:0] ST_CODE     = 3'h4;
	localparam logic [2:0] ST_MEM_READ = 3'h5;
	localparam logic [2:0] ST_MEM_WRIT = 3'h6;
	localparam logic [2:0] ST_PASSIVE  = 3'h7;
	// Cycle sequencer states
	typedef enum logic [1:0] {
		PH_IDLE   = 2'b00,
		PH_LATCH  = 2'b01,
		PH_CMD    = 2'b10
	} phase_t;
endpackage : bus_cmd_pkg

// file: sync_two_ff.sv
/*
 * Two flip-flop synchroniser for one asynchronous level.
 * Assumes the destination clock is sys_clk and reset is asynchronous, active high.
 */
module sync_two_ff #(
	parameter logic RESET_VALUE = 1'b0
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic asyncIn,
	output logic      syncOut
);
	// First stage, read only by the second stage
	logic meta;

	// Register both stages
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta    <= RESET_VALUE;
			syncOut <= RESET_VALUE;
		end else begin
			meta    <= asyncIn;
			syncOut <= meta;
		end
	end
endmodule : sync_two_ff

// file: bus_command_controller.sv
/*
 * Bus command controller: decodes the processor status word into active-low command
 * strobes and drives address latch, transceiver enable, direction and cascade/peripheral enable.
 * Assumes status, grant, qualifier and strap are asynchronous pins and are synchronised here;
 * the pin buffers outside turn each command output enable into a three-state driver.
 */
// How it works
// - Status word decodes into one command
// - Strap high selects I/O-bus mode
// - Commands enabled at least 105 ns after grant
// - Grant loss floats command drivers on the third clock edge
// - I/O-bus mode ignores grant for I/O commands
// - Direction high on writes, low on reads
// - Address strobe pulses high each machine cycle
// - Early writes share read strobe timing
// - All command strobes are active low
// - Qualifier low forces commands, data and peripheral enables inactive
// - Data enable high during memory cycles and system-bus I/O reads and writes
// - System-bus mode: cascade enable on interrupts
// - I/O-bus mode: active-low peripheral enable
// - I/O-bus mode starts I/O strobes at once
// - All outputs timed from the clock
// - System-bus commands wait 115 ns after grant
// - Qualifier low drives inactive, not floating
// - Address strobe also latches the status word
module bus_command_controller #(
	parameter int ISSUE_CYC  = bus_cmd_pkg::GRANT_ISSUE_CYC,
	parameter int ENABLE_CYC = bus_cmd_pkg::GRANT_ENABLE_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [2:0] cpu_status_lines,
	input  wire logic       io_bus_mode_strap,
	input  wire logic       arbiter_bus_grant_n,
	input  wire logic       command_qualifier,
	output logic            addrLatchStrobe,
	output logic            data_xcvr_enable,
	output logic            data_direction,
	output logic            cascadePeriphEnable,
	output logic            mem_read_strobe_n,
	output logic            mem_write_strobe_n,
	output logic            early_mem_write_strobe_n,
	output logic            io_read_strobe_n,
	output logic            io_write_strobe_n,
	output logic            early_io_write_strobe_n,
	output logic            irq_ack_strobe_n,
	output logic            memCmdOutEnable,
	output logic            ioCmdOutEnable
);
	// Refuse grant delay counts that the saturating 8-bit counter cannot serve
	if (ISSUE_CYC < 1 || ISSUE_CYC > 255 || ENABLE_CYC < 1 || ENABLE_CYC > ISSUE_CYC) begin : gBadCounts
		$error("bus_command_controller: grant delay counts out of range");
	end

	// Synchronised pin inputs
	logic [2:0] statusSync;
	logic       ioMode;
	logic       grantN;
	logic       qualifier;

	// Synchronise each status line, passive (high) during reset
	for (genvar i = 0; i < bus_cmd_pkg::STATUS_W; i++) begin : gStatus
		sync_two_ff #(.RESET_VALUE(1'b1)) uSync (
			.sys_clk (sys_clk),
			.rst     (rst),
			.asyncIn (cpu_status_lines[i]),
			.syncOut (statusSync[i])
		);
	end

	// Mode strap synchroniser
	sync_two_ff #(.RESET_VALUE(1'b0)) uStrap (
		.sys_clk (sys_clk),
		.rst     (rst),
		.asyncIn (io_bus_mode_strap),
		.syncOut (ioMode)
	);

	// Bus grant synchroniser, not granted during reset
	sync_two_ff #(.RESET_VALUE(1'b1)) uGrant (
		.sys_clk (sys_clk),
		.rst     (rst),
		.asyncIn (arbiter_bus_grant_n),
		.syncOut (grantN)
	);

	// Command qualifier synchroniser, disabled during reset
	sync_two_ff #(.RESET_VALUE(1'b0)) uQual (
		.sys_clk (sys_clk),
		.rst     (rst),
		.asyncIn (command_qualifier),
		.syncOut (qualifier)
	);

	// Sequencer and latched cycle state
	bus_cmd_pkg::phase_t phase, next_phase;
	logic [2:0] latchedStatus, next_latchedStatus;  // Status word captured by the address strobe
	logic [7:0] grantCount, next_grantCount;        // Cycles since grant went low, saturating

	// Decoded command classes of the latched word
	logic isIrqAck, isIoRead, isIoWrite, isMemRead, isMemWrite, isIoCycle, isWrite, isCmd;
	logic statusActive;

	always_comb begin
		statusActive = (statusSync != bus_cmd_pkg::ST_PASSIVE) && (statusSync != bus_cmd_pkg::ST_HALT);
		isIrqAck     = (latchedStatus == bus_cmd_pkg::ST_IRQ_ACK);
		isIoRead     = (latchedStatus == bus_cmd_pkg::ST_IO_READ);
		isIoWrite    = (latchedStatus == bus_cmd_pkg::ST_IO_WRITE);
		isMemRead    = (latchedStatus == bus_cmd_pkg::ST_CODE) || (latchedStatus == bus_cmd_pkg::ST_MEM_READ);
		isMemWrite   = (latchedStatus == bus_cmd_pkg::ST_MEM_WRIT);
		isIoCycle    = isIrqAck || isIoRead || isIoWrite;
		isWrite      = isIoWrite || isMemWrite;
		isCmd        = isIoCycle || isMemRead || isMemWrite;  // Halt and passive issue nothing
	end

	// Grant gating per command class
	logic memGranted, ioGranted, memIssue, ioIssue;
	always_comb begin
		memGranted = (grantCount >= 8'(ENABLE_CYC));
		memIssue   = (grantCount >= 8'(ISSUE_CYC));
		ioGranted  = ioMode ? 1'b1 : memGranted;
		ioIssue    = ioMode ? 1'b1 : memIssue;
	end

	// Next-state logic of sequencer, status latch and grant counter
	always_comb begin
		next_phase         = phase;
		next_latchedStatus = latchedStatus;
		next_grantCount    = grantCount;
		// Count grant time; loss of grant restarts the wait
		if (grantN)
			next_grantCount = 8'h00;
		else if (grantCount != 8'hFF)
			next_grantCount = grantCount + 8'h01;
		unique case (phase)
			bus_cmd_pkg::PH_IDLE: begin
				// Status going active starts a machine cycle
				if (statusActive) begin
					next_phase         = bus_cmd_pkg::PH_LATCH;
					next_latchedStatus = statusSync;
				end
			end
			bus_cmd_pkg::PH_LATCH: begin
				next_phase = bus_cmd_pkg::PH_CMD;
			end
			bus_cmd_pkg::PH_CMD: begin
				// Passive status ends the bus cycle
				if (statusSync == bus_cmd_pkg::ST_PASSIVE) begin
					next_phase         = bus_cmd_pkg::PH_IDLE;
					next_latchedStatus = bus_cmd_pkg::ST_PASSIVE;
				end
			end
			default: next_phase = bus_cmd_pkg::PH_IDLE;
		endcase
	end

	// Register sequencer state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			phase         <= bus_cmd_pkg::PH_IDLE;
			latchedStatus <= bus_cmd_pkg::ST_PASSIVE;
			grantCount    <= 8'h00;
		end else begin
			phase         <= next_phase;
			latchedStatus <= next_latchedStatus;
			grantCount    <= next_grantCount;
		end
	end

	// Output next values
	logic next_ale, next_xcvrOn, next_dir, next_dualPin;
	logic next_mrd, next_mwr, next_amw, next_ird, next_iwr, next_aiw, next_ack;
	logic next_memOe, next_ioOe;
	logic inCmd, late;

	always_comb begin
		inCmd    = (phase == bus_cmd_pkg::PH_CMD) && isCmd;
		late     = inCmd && (statusSync != bus_cmd_pkg::ST_PASSIVE);
		// Strobe high for the first cycle of each machine cycle
		next_ale = (phase == bus_cmd_pkg::PH_IDLE) && statusActive;
		next_dir = late && isWrite;
		// Read-timed strobes, active low
		next_mrd = ~(qualifier && late && isMemRead && memIssue);
		next_amw = ~(qualifier && late && isMemWrite && memIssue);
		next_ird = ~(qualifier && late && isIoRead && ioIssue);
		next_aiw = ~(qualifier && late && isIoWrite && ioIssue);
		next_ack = ~(qualifier && late && isIrqAck && ioIssue);
		// Normal writes wait one cycle after the advanced ones
		next_mwr = ~(qualifier && late && isMemWrite && memIssue && !early_mem_write_strobe_n);
		next_iwr = ~(qualifier && late && isIoWrite && ioIssue && !early_io_write_strobe_n);
		// Data enable on the system-side transceiver
		next_xcvrOn = qualifier && late && (ioMode ? !isIoCycle : 1'b1) && !isIrqAck;
		// Dual-function pin by mode
		if (ioMode)
			next_dualPin = ~(qualifier && late && isIoCycle);
		else
			next_dualPin = (phase == bus_cmd_pkg::PH_LATCH) && isIrqAck;
		// Driver enables; qualifier never floats the outputs
		next_memOe = !grantN && memGranted;
		next_ioOe  = ioMode ? 1'b1 : (!grantN && ioGranted);
	end

	// Register all outputs
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			addrLatchStrobe          <= 1'b0;
			data_xcvr_enable         <= 1'b0;
			data_direction           <= 1'b0;
			cascadePeriphEnable      <= 1'b0;
			mem_read_strobe_n        <= 1'b1;
			mem_write_strobe_n       <= 1'b1;
			early_mem_write_strobe_n <= 1'b1;
			io_read_strobe_n         <= 1'b1;
			io_write_strobe_n        <= 1'b1;
			early_io_write_strobe_n  <= 1'b1;
			irq_ack_strobe_n         <= 1'b1;
			memCmdOutEnable          <= 1'b0;
			ioCmdOutEnable           <= 1'b0;
		end else begin
			addrLatchStrobe          <= next_ale;
			data_xcvr_enable         <= next_xcvrOn;
			data_direction           <= next_dir;
			cascadePeriphEnable      <= next_dualPin;
			mem_read_strobe_n        <= next_mrd;
			mem_write_strobe_n       <= next_mwr;
			early_mem_write_strobe_n <= next_amw;
			io_read_strobe_n         <= next_ird;
			io_write_strobe_n        <= next_iwr;
			early_io_write_strobe_n  <= next_aiw;
			irq_ack_strobe_n         <= next_ack;
			memCmdOutEnable          <= next_memOe;
			ioCmdOutEnable           <= next_ioOe;
		end
	end

	// Helper: a strobe being active
	logic anyCmd;
	assign anyCmd = !(mem_read_strobe_n && mem_write_strobe_n && early_mem_write_strobe_n &&
		io_read_strobe_n && io_write_strobe_n && early_io_write_strobe_n && irq_ack_strobe_n);

	sequence grantFall_s;
		$fell(grantN);
	endsequence

	sequence memHeldOff_s;
		mem_read_strobe_n [*3];
	endsequence

	// Checks on decoding, grant timing and strobe order
	decode_halt_a: assert property (@(posedge sys_clk) disable iff (rst)
		(phase == bus_cmd_pkg::PH_IDLE && statusSync == bus_cmd_pkg::ST_HALT) |=>
		(!anyCmd && !addrLatchStrobe))
		else $error("halt status started a bus cycle");
	mode_io_a: assert property (@(posedge sys_clk) disable iff (rst)
		ioMode |=> ioCmdOutEnable)
		else $error("I/O-bus mode did not enable I/O drivers");
	grant_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
		grantFall_s |-> !memCmdOutEnable [*5])
		else $error("memory drivers enabled too soon after grant");
	grant_float_a: assert property (@(posedge sys_clk) disable iff (rst)
		grantN |=> !memCmdOutEnable)
		else $error("memory drivers not floated on grant loss");
	dir_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		!early_mem_write_strobe_n |-> data_direction)
		else $error("direction low during memory write");
	ale_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(addrLatchStrobe) |=> !addrLatchStrobe)
		else $error("address strobe longer than one cycle");
	early_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(mem_write_strobe_n) |-> $past(!early_mem_write_strobe_n))
		else $error("normal write before advanced write");
	qual_off_a: assert property (@(posedge sys_clk) disable iff (rst)
		!qualifier |=> !anyCmd && !data_xcvr_enable)
		else $error("command active with qualifier low");
	issue_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
		grantFall_s |-> memHeldOff_s)
		else $error("memory command issued too soon after grant");
	cycle_end_a: assert property (@(posedge sys_clk) disable iff (rst)
		(phase == bus_cmd_pkg::PH_CMD && statusSync == bus_cmd_pkg::ST_PASSIVE) |=> !anyCmd)
		else $error("command outlived passive status");

	// Checks on mode, transceiver and latch behaviour
	io_no_grant_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ioMode && grantN && qualifier && phase == bus_cmd_pkg::PH_CMD && isIoRead &&
		statusSync != bus_cmd_pkg::ST_PASSIVE) |=> !io_read_strobe_n)
		else $error("I/O read held back by grant in I/O-bus mode");
	periph_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
		($past(ioMode) && !io_read_strobe_n) |-> !cascadePeriphEnable)
		else $error("peripheral enable idle during I/O read");
	cascade_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
		(!$past(ioMode) && $rose(cascadePeriphEnable)) |-> $past(addrLatchStrobe))
		else $error("cascade enable outside an interrupt cycle start");
	xcvr_read_a: assert property (@(posedge sys_clk) disable iff (rst)
		!mem_read_strobe_n |-> (data_xcvr_enable && !data_direction))
		else $error("transceiver not set for memory read");
	latch_status_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(addrLatchStrobe) |-> (latchedStatus == $past(statusSync)))
		else $error("status word not latched with address strobe");
	early_io_a: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(io_write_strobe_n) |-> $past(!early_io_write_strobe_n))
		else $error("normal I/O write before advanced write");
endmodule : bus_command_controller

// file: cpu_arbiter_model.sv
/* Processor status lines and bus arbiter grant, modelled for the command controller bench.
   Assumes the bench calls its tasks; every change lands on a falling clock edge. */
module cpu_arbiter_model (
	input  wire logic       sys_clk,
	output logic      [2:0] cpu_status_lines,
	output logic            arbiter_bus_grant_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Status passive and bus not granted until told otherwise
	initial begin
		cpu_status_lines    = 3'h7;
		arbiter_bus_grant_n = 1'b1;
	end
	// Open a bus cycle with the given status word
	task automatic start_cycle(input logic [2:0] code);
		@(negedge sys_clk);
		cpu_status_lines = code;
	endtask : start_cycle
	// Close the cycle by returning to passive
	task automatic end_cycle();
		@(negedge sys_clk);
		cpu_status_lines = 3'h7;
	endtask : end_cycle
	// Arbiter grants (low) or withdraws (high) the bus
	task automatic set_grant(input logic grantN);
		@(negedge sys_clk);
		arbiter_bus_grant_n = grantN;
	endtask : set_grant
endmodule : cpu_arbiter_model

// file: tb_cpu_status_bus_command_controller.sv
/* Self-checking bench for the bus command controller.
   Assumes the model drives status and grant; strap and qualifier come from here. */
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
	$display("CHECK FAILED at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_cpu_status_bus_command_controller;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk;      // 50 MHz clock
	logic       rst;          // Asynchronous reset
	logic [2:0] statusLines;  // Status word from the model
	logic       grantN;       // Grant from the model
	logic       ioMode;       // Mode strap
	logic       qualifier;    // Command qualifier
	logic       ale, dataEn, dir, casc, memEn, ioEn;
	logic       memRdN, memWrN, earlyMemWrN, ioRdN, ioWrN, earlyIoWrN, irqAckN;  // Command strobes
	logic [6:0] strobesN;     // Irq, early io wr, io wr, io rd, early mem wr, mem wr, mem rd
	logic [6:0] lowMask;      // Strobes seen low in a watch
	logic       sawAle, sawDataEn, sawCasc, sawPeriphEn, earlyLead, dirSeen;
	int         errors;
	int         comparisons;
	localparam logic [6:0] EXP_MASK [8] = '{7'h40, 7'h08, 7'h30, 7'h00, 7'h01, 7'h01, 7'h06, 7'h00};

	cpu_arbiter_model cpu (.sys_clk(sys_clk), .cpu_status_lines(statusLines), .arbiter_bus_grant_n(grantN));
	bus_command_controller DUT (
		.sys_clk(sys_clk), .rst(rst), .cpu_status_lines(statusLines), .io_bus_mode_strap(ioMode),
		.arbiter_bus_grant_n(grantN), .command_qualifier(qualifier), .addrLatchStrobe(ale),
		.data_xcvr_enable(dataEn), .data_direction(dir), .cascadePeriphEnable(casc),
		.mem_read_strobe_n(memRdN), .mem_write_strobe_n(memWrN),
		.early_mem_write_strobe_n(earlyMemWrN), .io_read_strobe_n(ioRdN),
		.io_write_strobe_n(ioWrN), .early_io_write_strobe_n(earlyIoWrN),
		.irq_ack_strobe_n(irqAckN), .memCmdOutEnable(memEn), .ioCmdOutEnable(ioEn));

	// Strobes gathered into one word, bit order as listed above
	assign strobesN = {irqAckN, earlyIoWrN, ioWrN, ioRdN, earlyMemWrN, memWrN, memRdN};

	// Clock generator
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Print counts and verdict, then stop
	task automatic wrap_up();
		$display("Comparisons %0d, errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up

	// Gather what the outputs did over n cycles, sampled at falling edges
	task automatic watch(input int n);
		repeat (n) begin
			@(negedge sys_clk);
			lowMask |= ~strobesN;
			sawAle |= ale;
			sawDataEn |= dataEn;
			sawCasc |= casc;
			sawPeriphEn |= ~casc;
			earlyLead |= (!strobesN[2] && strobesN[1]) || (!strobesN[5] && strobesN[4]);
			if (strobesN !== 7'h7F) begin
				dirSeen = dir;
			end
		end
	endtask : watch

	// One whole cycle, then check it ended cleanly
	task automatic run_cycle(input logic [2:0] code);
		lowMask = 7'h00;
		{sawAle, sawDataEn, sawCasc, sawPeriphEn, earlyLead, dirSeen} = 6'h00;
		cpu.start_cycle(code);
		watch(14);
		cpu.end_cycle();
		repeat (6) @(negedge sys_clk);
		`CHECK({strobesN, dataEn}, 8'hFE)
	endtask : run_cycle

	// Every status word in system-bus mode with the bus granted
	task automatic sc_decode();
		logic [2:0] code;
		for (int i = 0; i < 8; i++) begin
			code = 3'(i);
			run_cycle(code);
			`CHECK(lowMask, EXP_MASK[i])
			`CHECK(sawAle, (code != 3'h3 && code != 3'h7))
			`CHECK(sawDataEn, (EXP_MASK[i] != 7'h00 && code != 3'h0))
			`CHECK(sawCasc, (code == 3'h0))
			`CHECK(dirSeen, (code == 3'h2 || code == 3'h6))
			`CHECK(earlyLead, (code == 3'h2 || code == 3'h6))
		end
	endtask : sc_decode

	// Command waits for the grant and floats when it is withdrawn
	task automatic sc_grant();
		int cnt;
		cpu.set_grant(1'b1);
		cpu.start_cycle(3'h5);
		repeat (10) @(negedge sys_clk);
		`CHECK({strobesN[0], memEn}, 2'h2)
		cpu.set_grant(1'b0);
		cnt = 0;
		while (strobesN[0] !== 1'b0 && cnt < 40) begin
			@(negedge sys_clk);
			cnt++;
		end
		if (cnt == 40) begin
			errors++;
			wrap_up();
		end
		`CHECK(cnt >= bus_cmd_pkg::GRANT_ISSUE_CYC, 1'b1)
		`CHECK(memEn, 1'b1)
		cpu.set_grant(1'b1);
		repeat (3) @(negedge sys_clk);
		`CHECK({memEn, ioEn}, 2'h0)
		cpu.end_cycle();
		cpu.set_grant(1'b0);
		repeat (10) @(negedge sys_clk);
	endtask : sc_grant

	// I/O-bus mode without a grant: I/O commands run, memory waits
	task automatic sc_iomode();
		@(negedge sys_clk);
		ioMode = 1'b1;
		cpu.set_grant(1'b1);
		repeat (4) @(negedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			run_cycle(3'(i));
			`CHECK(lowMask, (i < 3 ? EXP_MASK[i] : 7'h00))
			`CHECK(ioEn, 1'b1)
			`CHECK(sawPeriphEn, (i < 3))
		end
	endtask : sc_iomode

	// Qualifier low keeps commands inactive in both modes, peripheral enable in I/O-bus mode, data enable in system-bus mode
	task automatic sc_qualifier();
		@(negedge sys_clk);
		qualifier = 1'b0;
		run_cycle(3'h1);
		`CHECK({lowMask, sawPeriphEn}, 8'h00)
		@(negedge sys_clk);
		ioMode = 1'b0;
		cpu.set_grant(1'b0);
		run_cycle(3'h6);
		`CHECK({lowMask, sawDataEn, memEn}, 9'h001)
	endtask : sc_qualifier

	// Main sequence
	initial begin
		rst = 1'b1;
		ioMode = 1'b0;
		qualifier = 1'b1;
		errors = 0;
		comparisons = 0;
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		cpu.set_grant(1'b0);
		repeat (10) @(negedge sys_clk);
		sc_decode();
		sc_grant();
		sc_iomode();
		sc_qualifier();
		wrap_up();
	end
endmodule : tb_cpu_status_bus_command_controller
